// ### logic/sfm_pkg.sv
// constants and types shared by the serial fault monitor
package sfm_pkg;

   // ==========================================================
   // widths
   localparam int SFM_DW   = 16;
   localparam int SFM_CLW  = 5;
   localparam int SFM_DLYW = 8;
   localparam int SFM_CNTW = 10;
   localparam int SFM_NFLG = 4;

   // ==========================================================
   // flag positions in word status, flags and enables
   localparam int SFM_F_BIT  = 0;
   localparam int SFM_F_DSY  = 1;
   localparam int SFM_F_TMO  = 2;
   localparam int SFM_F_LEN  = 3;

   // ==========================================================
   // reset values and timing
   localparam logic [SFM_DW-1:0]   SFM_WORD_RST = 16'h0000;
   localparam logic [SFM_NFLG-1:0] SFM_FLG_RST  = 4'h0;
   localparam logic [SFM_CNTW-1:0] SFM_SAMP_ADD = 10'h002;
   localparam logic [SFM_CNTW-1:0] SFM_ONE      = 10'h001;
   localparam logic [SFM_CLW-1:0]  SFM_LAST_BIT = 5'h01;
   localparam logic [SFM_DLYW-1:0] SFM_DLY_OFF  = 8'h00;
   localparam logic [4:0]          SFM_SYNC_RST = 5'h1D;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      SFM_PIN3,
      SFM_PIN4_CS,
      SFM_PIN4_ENA,
      SFM_PIN5
   } sfm_pinmode_type;

   typedef enum logic [2:0] {
      SFM_IDLE,
      SFM_C2T,
      SFM_C2E,
      SFM_SHIFT,
      SFM_T2C,
      SFM_T2E
   } sfm_state_type;

endpackage

// ### logic/sfm_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module sfm_sync #(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST;
         q      <= RST;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // sfm_sync

// ### logic/sfm_fault_monitor.sv
// serial master with loopback, bit check, handshake timeouts
// Functional notes
// - loopback feeds transmit into receiver, data and clock pins undriven
// - own data pin read back at sample edge; mismatch flags bit error
// - bit readback comparison is off while loopback is on
// - enable line watched only in four-pin-enable and five-pin modes
// - enable released mid character is a slave_word_bit_a
// - eight-bit end-to-release delay bounds the release wait
// - slave_word_bit_a sets word bit and sticky flag, interrupt if enabled
// - release wait starts after end-to-select delay or shifting
// - enable sampled every divider+2 clocks; wait max delay+divider+2
// - release wait only if enable asserted, delay nonzero, wait bit set
// - five-pin response wait starts after select-to-transfer delay
// - response timeout sets word bit and flag, aborts transfer
// - response wait ends at sampled enable; max delay+divider+2
// - response wait only if enable released and wait bit; zero waits forever
// - master: enable released before last bit is length error
// - slave: select released before last bit is length error
// - hardware reset restores all state; clearing out-of-reset bit restores all but pin synchronisers and readback delay
// - sleep bit freezes sequencer and slave length counter until cleared
// - flag clears still act while asleep
`timescale 1ns/10ps
module sfm_fault_monitor
   import sfm_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     out_of_reset,
   input  wire logic                     local_sleep_bit,
   input  wire logic                     master_mode,
   input  wire logic                     loopback_en,
   input  wire sfm_pkg::sfm_pinmode_type pin_mode,
   input  wire logic                     wait_for_slave_response,
   input  wire logic [7:0]               bit_rate_divider,
   input  wire logic [sfm_pkg::SFM_CLW-1:0]  char_len,
   input  wire logic [sfm_pkg::SFM_DLYW-1:0] select_to_xfer_delay,
   input  wire logic [sfm_pkg::SFM_DLYW-1:0] xfer_end_to_select_delay,
   input  wire logic [sfm_pkg::SFM_DLYW-1:0] select_to_response_delay,
   input  wire logic [sfm_pkg::SFM_DLYW-1:0] xfer_end_to_release_delay,
   input  wire logic [sfm_pkg::SFM_NFLG-1:0] flag_int_enable,
   input  wire logic [sfm_pkg::SFM_NFLG-1:0] flag_clear,
   input  wire logic [sfm_pkg::SFM_DW-1:0]   tx_data,
   input  wire logic                     tx_start,
   output logic                          serial_clock_pin_o,
   output logic                          serial_clock_pin_oe,
   input  wire logic                     serial_clock_pin_i,
   output logic                          master_out_pin_o,
   output logic                          master_out_pin_oe,
   input  wire logic                     master_out_pin_i,
   input  wire logic                     master_in_pin_i,
   input  wire logic                     slave_response_line_n_i,
   output logic                          slave_select_lines_n_o,
   output logic                          slave_select_lines_oe,
   input  wire logic                     slave_select_lines_n_i,
   output logic                          busy,
   output logic [sfm_pkg::SFM_DW-1:0]    rx_word,
   output logic                          rx_valid,
   output logic                          bit_mismatch_word_bit,
   output logic                          slave_word_bit_a,
   output logic                          timeout_word_bit,
   output logic                          length_word_bit,
   output logic                          bit_mismatch_flag,
   output logic                          slave_slave_word_bit_a_flag,
   output logic                          enable_wait_expired_flag,
   output logic                          length_error_flag,
   output logic                          error_irq
);

   // ==========================================================
   // declarations
   sfm_state_type           state_r;
   sfm_state_type           state_nxt;
   logic [SFM_CNTW-1:0]     cnt_r;
   logic [SFM_CNTW-1:0]     cnt_nxt;
   logic [SFM_CNTW-1:0]     div_r;
   logic [SFM_CNTW-1:0]     div_nxt;
   logic [SFM_DW-1:0]       tx_sr_r;
   logic [SFM_DW-1:0]       tx_sr_nxt;
   logic [SFM_DW-1:0]       rx_sr_r;
   logic [SFM_DW-1:0]       rx_sr_nxt;
   logic [SFM_CLW-1:0]      bits_r;
   logic [SFM_CLW-1:0]      bits_nxt;
   logic                    sclk_r;
   logic                    sclk_nxt;
   logic                    sel_r;
   logic                    sel_nxt;
   logic                    seen_r;
   logic                    seen_nxt;
   logic [SFM_NFLG-1:0]     err_r;
   logic [SFM_NFLG-1:0]     err_nxt;
   logic [SFM_NFLG-1:0]     ev;
   logic                    done;
   logic [SFM_NFLG-1:0]     flags_r;
   logic [SFM_NFLG-1:0]     flags_nxt;
   logic [SFM_NFLG-1:0]     word_err_r;
   logic [SFM_DW-1:0]       rx_word_r;
   logic                    rx_valid_r;
   logic                    irq_r;
   logic [4:0]              pins_s;
   logic [3:0]              rb_exp_r;
   logic                    miso_s;
   logic                    ena_s;
   logic                    rb_s;
   logic                    sclk_s;
   logic                    scs_s;
   logic                    sclk_q_r;
   logic                    scs_q_r;
   logic [SFM_CLW-1:0]      sl_cnt_r;
   logic [SFM_NFLG-1:0]     sl_ev;

   // ==========================================================
   // pin synchronisers
   sfm_sync #(
      .W   (5),
      .RST (SFM_SYNC_RST)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       ({master_in_pin_i, slave_response_line_n_i,
                 master_out_pin_i, serial_clock_pin_i,
                 slave_select_lines_n_i}),
      .q       (pins_s)
   );

   assign miso_s = pins_s[4];
   assign ena_s  = pins_s[3];
   assign rb_s   = pins_s[2];
   assign sclk_s = pins_s[1];
   assign scs_s  = pins_s[0];

   // driven pin delayed to line up with readback
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rb_exp_r <= '0;
      end else begin
         rb_exp_r <= {rb_exp_r[1:0], master_out_pin_oe, master_out_pin_o};
      end
   end

   // ==========================================================
   // decode
   wire srst     = ~out_of_reset;
   wire run      = ~local_sleep_bit;
   wire ena_act  = ~ena_s;
   wire five     = (pin_mode == SFM_PIN5);
   wire ena_func = five | (pin_mode == SFM_PIN4_ENA);
   wire scs_func = five | (pin_mode == SFM_PIN4_CS);
   wire [SFM_CNTW-1:0] div10 = {2'h0, bit_rate_divider};
   wire tick     = (div_r == div10 + SFM_ONE);
   wire [SFM_CNTW-1:0] c2e_lim = {2'h0, select_to_response_delay}
                                 + div10 + SFM_ONE;
   wire [SFM_CNTW-1:0] t2e_lim = {2'h0, xfer_end_to_release_delay}
                                 + div10 + SFM_ONE;
   wire [SFM_CNTW-1:0] c2t_lim = {2'h0, select_to_xfer_delay} - SFM_ONE;
   wire [SFM_CNTW-1:0] t2c_lim = {2'h0, xfer_end_to_select_delay}
                                 - SFM_ONE;
   wire c2t_on   = (select_to_xfer_delay != SFM_DLY_OFF);
   wire t2c_on   = (xfer_end_to_select_delay != SFM_DLY_OFF);
   wire c2e_go   = five & wait_for_slave_response & ~ena_act;
   wire c2e_lim_on = (select_to_response_delay != SFM_DLY_OFF);
   wire t2e_go   = ena_func & wait_for_slave_response
                   & (xfer_end_to_release_delay != SFM_DLY_OFF)
                   & ena_act;
   wire rx_bit   = loopback_en ? tx_sr_r[SFM_DW-1] : miso_s;
   wire bit_bad  = ~loopback_en & rb_exp_r[3] & (rb_s != rb_exp_r[2]);
   wire dsy_bad  = ena_func & seen_r & ~ena_act;
   wire [SFM_DW-1:0] tx_load = tx_data << (5'h10 - char_len);
   wire [SFM_NFLG-1:0] ev_all = (ev | sl_ev) & {SFM_NFLG{run}};

   // ==========================================================
   // master sequencer next state
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r + SFM_ONE;
      div_nxt   = tick ? '0 : div_r + SFM_ONE;
      tx_sr_nxt = tx_sr_r;
      rx_sr_nxt = rx_sr_r;
      bits_nxt  = bits_r;
      sclk_nxt  = sclk_r;
      sel_nxt   = sel_r;
      seen_nxt  = seen_r | (tick & ena_act);
      err_nxt   = err_r;
      ev        = '0;
      done      = 1'b0;
      case (state_r)
         SFM_IDLE: begin
            cnt_nxt  = '0;
            div_nxt  = '0;
            seen_nxt = 1'b0;
            sclk_nxt = 1'b0;
            if (tx_start && master_mode) begin
               tx_sr_nxt = tx_load;
               rx_sr_nxt = SFM_WORD_RST;
               bits_nxt  = char_len;
               sel_nxt   = 1'b1;
               err_nxt   = '0;
               if (c2t_on) begin
                  state_nxt = SFM_C2T;
               end else begin
                  state_nxt = c2e_go ? SFM_C2E : SFM_SHIFT;
               end
            end
         end
         SFM_C2T: begin
            if (cnt_r == c2t_lim) begin
               cnt_nxt   = '0;
               div_nxt   = '0;
               state_nxt = c2e_go ? SFM_C2E : SFM_SHIFT;
            end
         end
         SFM_C2E: begin
            if (tick && ena_act) begin
               cnt_nxt   = '0;
               div_nxt   = '0;
               state_nxt = SFM_SHIFT;
            end else if (c2e_lim_on && cnt_r == c2e_lim) begin
               ev[SFM_F_TMO]      = 1'b1;
               err_nxt[SFM_F_TMO] = 1'b1;
               done               = 1'b1;
               sel_nxt            = 1'b0;
               state_nxt          = SFM_IDLE;
            end
         end
         SFM_SHIFT: begin
            if (tick) begin
               sclk_nxt = ~sclk_r;
               if (!sclk_r) begin
                  rx_sr_nxt = {rx_sr_r[SFM_DW-2:0], rx_bit};
                  if (bit_bad) begin
                     ev[SFM_F_BIT]      = 1'b1;
                     err_nxt[SFM_F_BIT] = 1'b1;
                  end
                  if (dsy_bad) begin
                     ev[SFM_F_DSY]      = 1'b1;
                     ev[SFM_F_LEN]      = 1'b1;
                     err_nxt[SFM_F_DSY] = 1'b1;
                     err_nxt[SFM_F_LEN] = 1'b1;
                  end
               end else begin
                  tx_sr_nxt = tx_sr_r << 1;
                  bits_nxt  = bits_r - SFM_LAST_BIT;
                  if (bits_r == SFM_LAST_BIT) begin
                     cnt_nxt = '0;
                     div_nxt = '0;
                     if (t2c_on) begin
                        state_nxt = SFM_T2C;
                     end else if (t2e_go) begin
                        state_nxt = SFM_T2E;
                     end else begin
                        done      = 1'b1;
                        sel_nxt   = 1'b0;
                        state_nxt = SFM_IDLE;
                     end
                  end
               end
            end
         end
         SFM_T2C: begin
            if (cnt_r == t2c_lim) begin
               cnt_nxt = '0;
               div_nxt = '0;
               sel_nxt = 1'b0;
               if (t2e_go) begin
                  state_nxt = SFM_T2E;
               end else begin
                  done      = 1'b1;
                  state_nxt = SFM_IDLE;
               end
            end
         end
         SFM_T2E: begin
            if (tick && !ena_act) begin
               done      = 1'b1;
               sel_nxt   = 1'b0;
               state_nxt = SFM_IDLE;
            end else if (cnt_r == t2e_lim) begin
               ev[SFM_F_DSY]      = 1'b1;
               err_nxt[SFM_F_DSY] = 1'b1;
               done               = 1'b1;
               sel_nxt            = 1'b0;
               state_nxt          = SFM_IDLE;
            end
         end
         default: begin
            state_nxt = SFM_IDLE;
            sel_nxt   = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // sequencer registers, frozen while asleep
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= SFM_IDLE;
         cnt_r   <= '0;
         div_r   <= '0;
         tx_sr_r <= SFM_WORD_RST;
         rx_sr_r <= SFM_WORD_RST;
         bits_r  <= '0;
         sclk_r  <= 1'b0;
         sel_r   <= 1'b0;
         seen_r  <= 1'b0;
         err_r   <= '0;
      end else if (srst) begin
         state_r <= SFM_IDLE;
         cnt_r   <= '0;
         div_r   <= '0;
         tx_sr_r <= SFM_WORD_RST;
         rx_sr_r <= SFM_WORD_RST;
         bits_r  <= '0;
         sclk_r  <= 1'b0;
         sel_r   <= 1'b0;
         seen_r  <= 1'b0;
         err_r   <= '0;
      end else if (run) begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         div_r   <= div_nxt;
         tx_sr_r <= tx_sr_nxt;
         rx_sr_r <= rx_sr_nxt;
         bits_r  <= bits_nxt;
         sclk_r  <= sclk_nxt;
         sel_r   <= sel_nxt;
         seen_r  <= seen_nxt;
         err_r   <= err_nxt;
      end
   end

   // ==========================================================
   // slave length check on synchronised select and clock
   wire sl_on   = ~master_mode & scs_func;
   wire sl_rise = sclk_s & ~sclk_q_r & ~scs_s;
   wire sl_rel  = scs_s & ~scs_q_r;
   wire [SFM_CLW-1:0] sl_inc = sl_cnt_r + SFM_LAST_BIT;

   assign sl_ev = {sl_on & sl_rel & (sl_cnt_r != '0), 3'h0};

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q_r <= 1'b0;
         scs_q_r  <= 1'b1;
         sl_cnt_r <= '0;
      end else if (srst) begin
         sclk_q_r <= 1'b0;
         scs_q_r  <= 1'b1;
         sl_cnt_r <= '0;
      end else if (run) begin
         sclk_q_r <= sclk_s;
         scs_q_r  <= scs_s;
         if (!sl_on || sl_rel) begin
            sl_cnt_r <= '0;
         end else if (sl_rise) begin
            sl_cnt_r <= (sl_inc == char_len) ? '0 : sl_inc;
         end
      end
   end

   // ==========================================================
   // sticky flags, receive word, interrupt
   assign flags_nxt = (flags_r & ~flag_clear) | ev_all;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r    <= SFM_FLG_RST;
         word_err_r <= SFM_FLG_RST;
         rx_word_r  <= SFM_WORD_RST;
         rx_valid_r <= 1'b0;
         irq_r      <= 1'b0;
      end else if (srst) begin
         flags_r    <= SFM_FLG_RST;
         word_err_r <= SFM_FLG_RST;
         rx_word_r  <= SFM_WORD_RST;
         rx_valid_r <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         flags_r    <= flags_nxt;
         irq_r      <= |(flags_nxt & flag_int_enable);
         rx_valid_r <= done & run;
         if (done && run) begin
            rx_word_r  <= rx_sr_r;
            word_err_r <= err_nxt;
         end
      end
   end

   // ==========================================================
   // outputs
   assign serial_clock_pin_o      = sclk_r;
   assign serial_clock_pin_oe     = sel_r & ~loopback_en;
   assign master_out_pin_o        = tx_sr_r[SFM_DW-1];
   assign master_out_pin_oe       = sel_r & ~loopback_en;
   assign slave_select_lines_n_o  = ~sel_r;
   assign slave_select_lines_oe   = master_mode & scs_func & ~srst;
   assign busy                    = (state_r != SFM_IDLE);
   assign rx_word                 = rx_word_r;
   assign rx_valid                = rx_valid_r;
   assign bit_mismatch_word_bit   = word_err_r[SFM_F_BIT];
   assign slave_word_bit_a        = word_err_r[SFM_F_DSY];
   assign timeout_word_bit        = word_err_r[SFM_F_TMO];
   assign length_word_bit         = word_err_r[SFM_F_LEN];
   assign bit_mismatch_flag       = flags_r[SFM_F_BIT];
   assign slave_slave_word_bit_a_flag       = flags_r[SFM_F_DSY];
   assign enable_wait_expired_flag = flags_r[SFM_F_TMO];
   assign length_error_flag       = flags_r[SFM_F_LEN];
   assign error_irq               = irq_r;

endmodule // sfm_fault_monitor

// ### tb/sfm_fm_chk.sv
// concurrent checks on the serial fault monitor ports
`timescale 1ns/10ps
module sfm_fm_chk (
   input logic                           sys_clk,
   input logic                           rst_n,
   input logic                           out_of_reset,
   input logic                           local_sleep_bit,
   input logic                           master_mode,
   input logic                           loopback_en,
   input sfm_pkg::sfm_pinmode_type       pin_mode,
   input logic                           wait_for_slave_response,
   input logic [sfm_pkg::SFM_NFLG-1:0]   flag_int_enable,
   input logic [sfm_pkg::SFM_NFLG-1:0]   flag_clear,
   input logic                           tx_start,
   input logic                           serial_clock_pin_o,
   input logic                           serial_clock_pin_oe,
   input logic                           master_out_pin_oe,
   input logic                           busy,
   input logic                           rx_valid,
   input logic                           slave_word_bit_a,
   input logic                           timeout_word_bit,
   input logic                           bit_mismatch_flag,
   input logic                           slave_slave_word_bit_a_flag,
   input logic                           enable_wait_expired_flag,
   input logic                           length_error_flag,
   input logic                           error_irq
);
   import sfm_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // assertions
   a_loop_pins_off: assert property (
      loopback_en && $past(loopback_en) && $past(loopback_en, 2)
      |-> !serial_clock_pin_oe && !master_out_pin_oe) else $error("pins driven in loopback");
   a_loop_no_check: assert property (
      loopback_en && $past(loopback_en, 4) |-> !$rose(bit_mismatch_flag))
      else $error("bit check active in loopback");
   a_slave_word_bit_a_mode_only: assert property (
      $rose(slave_slave_word_bit_a_flag) |-> master_mode && (pin_mode == SFM_PIN4_ENA || pin_mode == SFM_PIN5))
      else $error("slave_word_bit_a outside enable modes");
   a_tmo_five_pin: assert property (
      $rose(enable_wait_expired_flag) |-> pin_mode == SFM_PIN5 && wait_for_slave_response)
      else $error("timeout without five pin wait");
   a_word_with_valid: assert property (
      $rose(slave_word_bit_a) || $rose(timeout_word_bit) |-> rx_valid)
      else $error("word bit moved without word");
   a_dsy_sticky: assert property (
      slave_slave_word_bit_a_flag && !flag_clear[SFM_F_DSY] && out_of_reset |=> slave_slave_word_bit_a_flag)
      else $error("slave_word_bit_a flag lost");
   a_tmo_sticky: assert property (
      enable_wait_expired_flag && !flag_clear[SFM_F_TMO] && out_of_reset
      |=> enable_wait_expired_flag) else $error("timeout flag lost");
   a_irq_follows: assert property (
      error_irq == |({length_error_flag, enable_wait_expired_flag, slave_slave_word_bit_a_flag,
      bit_mismatch_flag} & $past(flag_int_enable))) else $error("irq mismatch");
   a_sleep_freeze: assert property (
      local_sleep_bit && $past(local_sleep_bit) && $past(out_of_reset)
      |-> $stable(busy) && $stable(serial_clock_pin_o)) else $error("logic ran asleep");
   a_sleep_refuse: assert property (
      tx_start && local_sleep_bit && !busy |=> !busy) else $error("start taken asleep");
   c_timeout: cover property (rx_valid && timeout_word_bit);
   c_slave_word_bit_a: cover property ($rose(slave_slave_word_bit_a_flag));
   c_length: cover property ($rose(length_error_flag));
endmodule // sfm_fm_chk
bind sfm_fault_monitor sfm_fm_chk u_chk (.*);

// ### tb/sfm_slave_model.sv
// behavioural far-side slave with enable handshake
`timescale 1ns/10ps
module sfm_slave_model (
   input  logic        sclk,
   input  logic        sel_n,
   input  logic [1:0]  mode,
   input  logic [15:0] resp,
   output logic        ena_n,
   output logic        miso
);
   logic [15:0] sh_r  = 16'h0000;
   int          rises = 0;
   // modes: 0 answer, 1 silent, 2 stuck asserted, 3 drop mid character
   always @(negedge sel_n) begin
      sh_r  <= resp;
      rises <= 0;
   end
   always @(negedge sclk) if (!sel_n) sh_r <= sh_r << 1;
   always @(posedge sclk) if (!sel_n) rises <= rises + 1;
   // released data line shows inverse of last bit
   assign miso  = sel_n ? ~sh_r[15] : sh_r[15];
   assign ena_n = (mode == 2'h0) ? sel_n : (mode == 2'h1) ? 1'b1 :
                  (mode == 2'h2) ? 1'b0 : (sel_n | (rises >= 2));
endmodule // sfm_slave_model

// ### tb/tb.sv
// self-checking bench for the serial fault monitor
`timescale 1ns/10ps
module tb;
   import sfm_pkg::*;
   logic sys_clk = 0, rst_n = 0, out_of_reset = 0, local_sleep_bit = 0, master_mode = 1;
   logic loopback_en = 0, wait_for_slave_response = 0, tx_start = 0, flip = 0;
   logic serial_clock_pin_i = 0, slave_select_lines_n_i = 1;
   sfm_pinmode_type pin_mode = SFM_PIN3;
   logic [7:0] bit_rate_divider = 8'h01, select_to_xfer_delay = 0, xfer_end_to_select_delay = 0;
   logic [7:0] select_to_response_delay = 0, xfer_end_to_release_delay = 0;
   logic [4:0] char_len = 5'h08;
   logic [3:0] flag_int_enable = 4'hF, flag_clear = 4'h0;
   logic [15:0] tx_data = 0, sresp = 16'h5A00, rx_word;
   logic [1:0] smode = 0;
   logic serial_clock_pin_o, serial_clock_pin_oe, master_out_pin_o, master_out_pin_oe;
   logic master_out_pin_i, master_in_pin_i, slave_response_line_n_i, slave_select_lines_n_o;
   logic slave_select_lines_oe, busy, rx_valid, bit_mismatch_word_bit, slave_word_bit_a;
   logic timeout_word_bit, length_word_bit, bit_mismatch_flag, slave_slave_word_bit_a_flag;
   logic enable_wait_expired_flag, length_error_flag, error_irq;
   int err_count = 0, comparisons = 0, cyc = 0, ca = 0;
   wire [15:0] flg = {12'h000, length_error_flag, enable_wait_expired_flag,
                      slave_slave_word_bit_a_flag, bit_mismatch_flag};
   wire [15:0] wbit = {12'h000, length_word_bit, timeout_word_bit,
                       slave_word_bit_a, bit_mismatch_word_bit};
   // no select pin in use: frame follows busy
   wire sclk_w = serial_clock_pin_oe ? serial_clock_pin_o : serial_clock_pin_i;
   wire sel_w = slave_select_lines_oe ? slave_select_lines_n_o : ~busy;
   assign master_out_pin_i = master_out_pin_oe ? (master_out_pin_o ^ flip) : ~master_out_pin_o;
   always #2.5 sys_clk = ~sys_clk;
   sfm_fault_monitor dut (.*);
   sfm_slave_model u_slave (.sclk(sclk_w), .sel_n(sel_w), .mode(smode), .resp(sresp),
                            .ena_n(slave_response_line_n_i), .miso(master_in_pin_i));
   // ==========================================
   // tasks
   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task start(input logic [15:0] d);
      tx_data = d;
      tx_start = 1;
      tick(1);
      tx_start = 0;
      cyc = 0;
   endtask
   task fin;
      while (!rx_valid) begin
         tick(1);
         cyc++;
         if (cyc > 3000) begin
            err_count++;
            $display("ERROR %0t no word", $time);
            print_verdict;
         end
      end
   endtask
   task clr;
      flag_clear = 4'hF;
      tick(1);
      flag_clear = 4'h0;
      tick(1);
   endtask
   task sframe(input int n);
      slave_select_lines_n_i = 0;
      repeat (n) begin
         #40 serial_clock_pin_i = 1;
         #40 serial_clock_pin_i = 0;
      end
      #40 slave_select_lines_n_i = 1;
      tick(8);
   endtask
   // ==========================================
   // sequence
   initial begin
      tick(2);
      rst_n = 1;
      out_of_reset = 1;
      tick(1);
      loopback_en = 1;
      flip = 1;
      start(16'h00A5);
      fin;
      chk(rx_word, 16'h00A5);
      chk(flg, 16'h0000);
      loopback_en = 0;
      $display("test loopback done");
      start(16'h0033);
      fin;
      chk(rx_word, 16'h005A);
      chk(wbit, 16'h0001);
      chk({15'h0000, error_irq}, 16'h0001);
      flip = 0;
      start(16'h0033);
      fin;
      chk(wbit, 16'h0000);
      chk(flg, 16'h0001);
      clr;
      chk({15'h0000, error_irq}, 16'h0000);
      $display("test bit check done");
      pin_mode = SFM_PIN5;
      wait_for_slave_response = 1;
      smode = 2'h1;
      select_to_response_delay = 8'h0A;
      start(16'h0011);
      fin;
      ca = cyc;
      chk(flg, 16'h0004);
      chk(wbit, 16'h0004);
      select_to_response_delay = 8'h1E;
      start(16'h0011);
      fin;
      chk(16'(cyc - ca), 16'h0014);
      select_to_response_delay = 8'h0A;
      select_to_xfer_delay = 8'h0A;
      start(16'h0011);
      fin;
      chk(16'(cyc - ca), 16'h000A);
      select_to_xfer_delay = 8'h00;
      select_to_response_delay = 8'h00;
      clr;
      start(16'h0011);
      tick(300);
      chk({15'h0000, busy}, 16'h0001);
      smode = 2'h0;
      fin;
      chk(flg, 16'h0000);
      $display("test response wait done");
      smode = 2'h2;
      xfer_end_to_release_delay = 8'h14;
      start(16'h0011);
      fin;
      ca = cyc;
      chk(flg, 16'h0002);
      chk(wbit, 16'h0002);
      clr;
      xfer_end_to_release_delay = 8'h28;
      start(16'h0011);
      fin;
      chk(16'(cyc - ca), 16'h0014);
      clr;
      xfer_end_to_release_delay = 8'h00;
      start(16'h0011);
      fin;
      chk(flg, 16'h0000);
      xfer_end_to_release_delay = 8'h14;
      wait_for_slave_response = 0;
      start(16'h0011);
      fin;
      chk(flg, 16'h0000);
      xfer_end_to_release_delay = 8'h00;
      wait_for_slave_response = 1;
      smode = 2'h3;
      for (int m = 0; m < 4; m++) begin
         clr;
         pin_mode = sfm_pinmode_type'(m);
         start(16'h0011);
         fin;
         chk(flg, (m >= 2) ? 16'h000A : 16'h0000);
      end
      $display("test slave_word_bit_a done");
      clr;
      master_mode = 0;
      pin_mode = SFM_PIN4_CS;
      char_len = 5'h04;
      sframe(3);
      chk(flg, 16'h0008);
      clr;
      sframe(4);
      chk(flg, 16'h0000);
      sframe(3);
      out_of_reset = 0;
      tick(1);
      chk(flg, 16'h0000);
      out_of_reset = 1;
      tick(1);
      sframe(3);
      local_sleep_bit = 1;
      master_mode = 1;
      start(16'h0011);
      tick(3);
      chk({15'h0000, busy}, 16'h0000);
      clr;
      chk(flg, 16'h0000);
      local_sleep_bit = 0;
      tick(1);
      start(16'h0011);
      fin;
      chk(rx_word, 16'h0005);
      $display("test slave reset sleep done");
      print_verdict;
   end
endmodule // tb
